//--- logic/rsod_map.svh
`ifndef RSOD_MAP_SVH
`define RSOD_MAP_SVH
// Configuration mode strap codes.
`define RSOD_MODE_SW_BOARD 2'h0
`define RSOD_MODE_SW_ADDIN 2'h1
`define RSOD_MODE_HW_EXT 2'h2
`define RSOD_MODE_HW_BASIC 2'h3
// I/O base addresses, 10-bit ISA space.
`define RSOD_FLOPPY_PRI_BASE 10'h3F6
`define RSOD_FLOPPY_SEC_BASE 10'h370
`define RSOD_DISK_PRI_BASE 10'h1F0
`define RSOD_DISK_SEC_BASE 10'h170
`define RSOD_SER_3F8 10'h3F8
`define RSOD_SER_2F8 10'h2F8
`define RSOD_SER_3E8 10'h3E8
`define RSOD_SER_2E8 10'h2E8
`define RSOD_PAR_378 10'h378
`define RSOD_PAR_278 10'h278
`define RSOD_PAR_3BC 10'h3BC
`define RSOD_REG_22 10'h022
`define RSOD_REG_24 10'h024
`define RSOD_REG_26E 10'h26E
`define RSOD_REG_398 10'h398
// Interrupt line numbers.
`define RSOD_IRQ_NONE 4'h0
`define RSOD_IRQ_3 4'h3
`define RSOD_IRQ_4 4'h4
`define RSOD_IRQ_5 4'h5
`define RSOD_IRQ_7 4'h7
// Delay from reset release to the second extended sample.
`define RSOD_SECOND_SAMPLE_NS 500
`define RSOD_CLK_PERIOD_NS 100
`define RSOD_SECOND_SAMPLE_CYCLES \
  ((`RSOD_SECOND_SAMPLE_NS + `RSOD_CLK_PERIOD_NS - 1) / `RSOD_CLK_PERIOD_NS)
`endif

//--- logic/rsod_pkg.sv
package rsod_pkg;
  typedef enum logic [1:0] {
    rsod_par_isa,
    rsod_par_ps2,
    rsod_par_epp,
    rsod_par_reserved
  } rsod_par_mode_type;
endpackage

//--- logic/rsod_serial_decode.sv
`timescale 1ns/100ps
`include "rsod_map.svh"
module rsod_serial_decode (
  input wire logic [3:0] serial_cfg_bits,
  output logic en_a,
  output logic [9:0] base_a,
  output logic [3:0] irq_a,
  output logic en_b,
  output logic [9:0] base_b,
  output logic [3:0] irq_b
);
  logic [2:0] sel_a;
  logic [2:0] sel_b;

  // Each port picks one of four ranges or off; code 0 is off.
  always_comb begin
    case (serial_cfg_bits)
      4'h1: begin sel_a = 3'h1; sel_b = 3'h0; end
      4'h2: begin sel_a = 3'h2; sel_b = 3'h0; end
      4'h3: begin sel_a = 3'h3; sel_b = 3'h0; end
      4'h4: begin sel_a = 3'h0; sel_b = 3'h1; end
      4'h5: begin sel_a = 3'h0; sel_b = 3'h3; end
      4'h6: begin sel_a = 3'h2; sel_b = 3'h1; end
      4'h7: begin sel_a = 3'h3; sel_b = 3'h1; end
      4'h8: begin sel_a = 3'h0; sel_b = 3'h2; end
      4'h9: begin sel_a = 3'h1; sel_b = 3'h2; end
      4'hA: begin sel_a = 3'h4; sel_b = 3'h0; end
      4'hB: begin sel_a = 3'h3; sel_b = 3'h2; end
      4'hC: begin sel_a = 3'h0; sel_b = 3'h4; end
      4'hD: begin sel_a = 3'h1; sel_b = 3'h4; end
      4'hE: begin sel_a = 3'h2; sel_b = 3'h4; end
      4'hF: begin sel_a = 3'h3; sel_b = 3'h4; end
      default: begin sel_a = 3'h0; sel_b = 3'h0; end
    endcase // [R09]
  end

  // Ranges at 3xx use line 4, ranges at 2xx use line 3; codes 7 and E share a line.
  function automatic logic [13:0] range_of(input logic [2:0] sel);
    case (sel)
      3'h1: range_of = {`RSOD_SER_3F8, `RSOD_IRQ_4};
      3'h2: range_of = {`RSOD_SER_2F8, `RSOD_IRQ_3};
      3'h3: range_of = {`RSOD_SER_3E8, `RSOD_IRQ_4};
      3'h4: range_of = {`RSOD_SER_2E8, `RSOD_IRQ_3};
      default: range_of = {10'h000, `RSOD_IRQ_NONE};
    endcase // [R10]
  endfunction

  assign en_a = (sel_a != 3'h0);
  assign en_b = (sel_b != 3'h0);
  assign {base_a, irq_a} = range_of(sel_a);
  assign {base_b, irq_b} = range_of(sel_b);
endmodule

//--- logic/rsod_parallel_decode.sv
`timescale 1ns/100ps
`include "rsod_map.svh"
module rsod_parallel_decode (
  input wire logic [1:0] parallel_cfg_bits,
  input wire logic [1:0] parallel_mode_strap,
  output logic en,
  output logic [9:0] base,
  output logic [3:0] irq,
  output rsod_pkg::rsod_par_mode_type mode
);
  // Address and interrupt from the two config bits.
  always_comb begin
    case (parallel_cfg_bits)
      2'h1: begin en = 1'b1; base = `RSOD_PAR_378; irq = `RSOD_IRQ_7; end
      2'h2: begin en = 1'b1; base = `RSOD_PAR_278; irq = `RSOD_IRQ_5; end
      2'h3: begin en = 1'b1; base = `RSOD_PAR_3BC; irq = `RSOD_IRQ_7; end
      default: begin en = 1'b0; base = 10'h000; irq = `RSOD_IRQ_NONE; end
    endcase // [R11]
  end

  // Straps can reach all four modes, code 3 giving the reserved mode; none gives the FIFO mode.
  always_comb begin
    case (parallel_mode_strap)
      2'h0: mode = rsod_pkg::rsod_par_isa;
      2'h1: mode = rsod_pkg::rsod_par_ps2;
      2'h2: mode = rsod_pkg::rsod_par_epp;
      default: mode = rsod_pkg::rsod_par_reserved;
    endcase // [R12] [R13]
  end
endmodule

//--- logic/rsod_strap_decoder.sv
`timescale 1ns/100ps
`include "rsod_map.svh"
// Summary of operation
// [R01] Hardware modes: two disk select straps enable floppy and disk interface.
// [R02] Drive code 00 off, 01 floppy primary, 10 both secondary, 11 both primary.
// [R03] Software modes ignore the disk select straps.
// [R04] Extended mode samples the six serial straps twice, into two banks.
// [R05] Basic and second bank: serial config bits 0-3, parallel config bits 0-1.
// [R06] First bank: clock, parallel mode, drive quantity, address select, voltage.
// [R07] Software modes take only clock, voltage and address select straps.
// [R08] Software modes: serial and parallel off, floppy two drives, disk primary.
// [R09] Serial code gives each port one of four ranges or off.
// [R10] Ranges at 3xx use interrupt 4, at 2xx interrupt 3.
// [R11] Parallel code: off, 378 irq7, 278 irq5, 3BC irq7.
// [R12] Parallel mode code: ISA, PS/2, EPP, reserved.
// [R13] Mode straps act only in extended mode; FIFO mode never strapped.
// [R14] Board must use 278 or 378 when strapping EPP.
// [R15] Clock strap tied low; zero means 24 MHz.
// [R16] Voltage strap: 0 is 5.0V, 1 is 3.3V; not in basic mode.
// [R17] Drive quantity: 0 two drives, 1 four; extended mode only.
// [R18] Board decodes extra drive selects for four drives.
// [R19] Sample at reset falling edge; extended resamples serial pins shortly after.
// [R20] Mode straps: 00 board, 01 add-in, 10 extended, 11 basic.
// [R21] Address select picks index/target pair per mode.
// [R22] Decoded options are held until next hard reset; overrides only in software mode.
module rsod_strap_decoder (
  // Clock, reset and hard reset level.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hard_reset_in,

  // Mode and drive straps.
  input wire logic [1:0] config_mode_strap,
  input wire logic disk_select_1_n,
  input wire logic disk_select_0_n,

  // Serial strap pins, raw levels.
  input wire logic serial_tx_port_a,
  input wire logic serial_tx_port_b,
  input wire logic request_send_a_n,
  input wire logic request_send_b_n,
  input wire logic terminal_ready_a_n,
  input wire logic terminal_ready_b_n,

  // Sampling status.
  output logic [1:0] config_mode,
  output logic config_done,

  // Drive units.
  output logic floppy_controller_en,
  output logic [9:0] floppy_controller_base,
  output logic floppy_four_drives,
  output logic disk_if_en,
  output logic [9:0] disk_if_base,

  // Serial ports.
  output logic serial_a_en,
  output logic [9:0] serial_a_base,
  output logic [3:0] serial_a_irq,
  output logic serial_b_en,
  output logic [9:0] serial_b_base,
  output logic [3:0] serial_b_irq,

  // Parallel port.
  output logic parallel_en,
  output logic [9:0] parallel_base,
  output logic [3:0] parallel_irq,
  output rsod_pkg::rsod_par_mode_type parallel_mode,

  // Chip-wide settings.
  output logic clock_is_24mhz,
  output logic voltage_3v3,
  output logic [9:0] config_reg_index_addr
);
  typedef enum logic [1:0] {
    rsod_idle,
    rsod_wait_second,
    rsod_done
  } rsod_state_type;

  localparam int unsigned SECOND_CYCLES = `RSOD_SECOND_SAMPLE_CYCLES;

  // Sequencer.
  rsod_state_type state;
  logic hard_reset_q;
  logic [3:0] wait_count;

  // Raw captures, held until the next hard reset.
  logic [1:0] mode;
  logic [1:0] drive_cfg;
  logic [5:0] bank_first;
  logic [5:0] bank_second;

  // Sample strobes.
  logic take_first;
  logic take_second;

  // Multi-bit strap fields.
  logic [3:0] serial_cfg_bits;
  logic [1:0] parallel_cfg_bits;
  logic [1:0] parallel_mode_strap;

  // Single-bit straps.
  logic clock_freq_strap;
  logic drive_quantity_strap;
  logic voltage_strap;
  logic register_addr_strap;

  // Latched mode, one-hot.
  logic hardware_basic_mode;
  logic hardware_extended_mode;
  logic software_board_mode;
  logic software_addin_mode;

  // Pins as one vector.
  logic [5:0] strap_pins;

  // Serial decoder results.
  logic ser_a_en_d;
  logic ser_b_en_d;
  logic [9:0] ser_a_base_d;
  logic [9:0] ser_b_base_d;
  logic [3:0] ser_a_irq_d;
  logic [3:0] ser_b_irq_d;

  // Parallel decoder results.
  logic par_en_d;
  logic [9:0] par_base_d;
  logic [3:0] par_irq_d;
  rsod_pkg::rsod_par_mode_type par_mode_d;

  // Next unit values.
  logic next_floppy_en;
  logic [9:0] next_floppy_base;
  logic next_disk_en;
  logic [9:0] next_disk_base;

  // Next register pair.
  logic [9:0] next_reg_addr;

  // Pin order within a bank: tx a, tx b, rts a, rts b, dtr a, dtr b.
  assign strap_pins = {terminal_ready_b_n, terminal_ready_a_n, request_send_b_n,
                       request_send_a_n, serial_tx_port_b, serial_tx_port_a};

  // A falling edge of the hard reset opens the first sample.
  assign take_first = hard_reset_q && !hard_reset_in; // [R19]
  assign take_second = (state == rsod_wait_second) && (wait_count == 4'h0); // [R04]

  // Last hard reset level; cleared, so no false edge follows reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hard_reset_q <= 1'b0;
    end else begin
      hard_reset_q <= hard_reset_in;
    end
  end

  // Sequencer; a new hard reset pulse always restarts it, so options hold until then.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= rsod_idle;
      wait_count <= 4'h0;
    end else if (hard_reset_in) begin
      state <= rsod_idle;
      wait_count <= 4'h0;
    end else begin
      case (state)
        rsod_idle: begin
          // Only extended mode waits for a second sample.
          if (take_first) begin
            if (config_mode_strap == `RSOD_MODE_HW_EXT) begin
              state <= rsod_wait_second; // [R19]
              wait_count <= 4'(SECOND_CYCLES - 1);
            end else begin
              state <= rsod_done;
            end
          end
        end

        rsod_wait_second: begin
          if (wait_count == 4'h0) begin
            state <= rsod_done;
          end else begin
            wait_count <= wait_count - 4'h1;
          end
        end

        rsod_done: state <= rsod_done;
        default: state <= rsod_idle;
      endcase
    end
  end

  // Raw strap capture; the second bank is resampled only in extended mode.
  // The second bank starts as a copy, so single-sample modes read it too.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode <= `RSOD_MODE_HW_BASIC;
      drive_cfg <= 2'h0;
      bank_first <= 6'h00;
      bank_second <= 6'h00;
    end else if (take_first) begin
      mode <= config_mode_strap; // [R20]
      drive_cfg <= {disk_select_1_n, disk_select_0_n}; // [R01]
      bank_first <= strap_pins; // [R04]
      bank_second <= strap_pins;
    end else if (take_second) begin
      bank_second <= strap_pins; // [R04]
    end
  end

  assign hardware_basic_mode = (mode == `RSOD_MODE_HW_BASIC);
  assign hardware_extended_mode = (mode == `RSOD_MODE_HW_EXT);
  assign software_board_mode = (mode == `RSOD_MODE_SW_BOARD);
  assign software_addin_mode = (mode == `RSOD_MODE_SW_ADDIN);

  // Field mapping per bank.
  assign serial_cfg_bits = bank_second[3:0]; // [R05]
  assign parallel_cfg_bits = bank_second[5:4]; // [R05]
  // In basic mode that pin is a serial code bit, so the clock stays at 24 MHz.
  assign clock_freq_strap = !hardware_basic_mode && bank_first[0]; // [R06] [R07] [R15]
  assign parallel_mode_strap = hardware_extended_mode ? bank_first[2:1] : 2'h0; // [R13]
  assign drive_quantity_strap = hardware_extended_mode && bank_first[3]; // [R17]
  assign register_addr_strap = bank_first[4]; // [R06] [R07]
  assign voltage_strap = !hardware_basic_mode && bank_first[5]; // [R16]

  rsod_serial_decode u_serial (
    .serial_cfg_bits(serial_cfg_bits),
    .en_a(ser_a_en_d),
    .base_a(ser_a_base_d),
    .irq_a(ser_a_irq_d),
    .en_b(ser_b_en_d),
    .base_b(ser_b_base_d),
    .irq_b(ser_b_irq_d)
  );

  rsod_parallel_decode u_parallel (
    .parallel_cfg_bits(parallel_cfg_bits),
    .parallel_mode_strap(parallel_mode_strap),
    .en(par_en_d),
    .base(par_base_d),
    .irq(par_irq_d),
    .mode(par_mode_d)
  );

  // Drive code decode; software modes force both units on at primary.
  always_comb begin
    next_floppy_en = 1'b1;
    next_floppy_base = `RSOD_FLOPPY_PRI_BASE;
    next_disk_en = 1'b1;
    next_disk_base = `RSOD_DISK_PRI_BASE;

    // These defaults are the software-mode values.
    if (!software_board_mode && !software_addin_mode) begin
      case (drive_cfg)
        2'h0: begin
          next_floppy_en = 1'b0; // [R02]
          next_disk_en = 1'b0;
        end
        2'h1: next_disk_en = 1'b0; // [R02]
        2'h2: begin
          next_floppy_base = `RSOD_FLOPPY_SEC_BASE; // [R02]
          next_disk_base = `RSOD_DISK_SEC_BASE;
        end
        default: next_disk_en = 1'b1;
      endcase
    end // [R03] [R08]
  end

  // Register pair: board mode uses low pairs, basic mode is fixed at 398.
  always_comb begin
    if (software_board_mode) begin
      next_reg_addr = register_addr_strap ? `RSOD_REG_24 : `RSOD_REG_22; // [R21]
    end else if (hardware_basic_mode) begin
      next_reg_addr = `RSOD_REG_398;
    end else begin
      next_reg_addr = register_addr_strap ? `RSOD_REG_398 : `RSOD_REG_26E; // [R21]
    end
  end

  // Outputs update once on completion and hold until the next hard reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Basic-mode idle values until the first sample completes.
      config_mode <= `RSOD_MODE_HW_BASIC;
      config_done <= 1'b0;

      floppy_controller_en <= 1'b0;
      floppy_controller_base <= 10'h000;
      floppy_four_drives <= 1'b0;
      disk_if_en <= 1'b0;
      disk_if_base <= 10'h000;

      serial_a_en <= 1'b0;
      serial_a_base <= 10'h000;
      serial_a_irq <= `RSOD_IRQ_NONE;
      serial_b_en <= 1'b0;
      serial_b_base <= 10'h000;
      serial_b_irq <= `RSOD_IRQ_NONE;
      parallel_en <= 1'b0;
      parallel_base <= 10'h000;
      parallel_irq <= `RSOD_IRQ_NONE;
      parallel_mode <= rsod_pkg::rsod_par_isa;
      clock_is_24mhz <= 1'b1;
      voltage_3v3 <= 1'b0;
      config_reg_index_addr <= `RSOD_REG_398;
    end else if (hard_reset_in) begin
      config_done <= 1'b0;
    end else if (state != rsod_done && (take_second ||
                 (take_first && config_mode_strap != `RSOD_MODE_HW_EXT))) begin
      config_done <= 1'b1; // [R22]
    end else if (config_done && state == rsod_done && !hard_reset_q) begin
      config_mode <= mode;

      // Drive units.
      floppy_controller_en <= next_floppy_en;
      floppy_controller_base <= next_floppy_base;
      floppy_four_drives <= drive_quantity_strap; // [R17]
      disk_if_en <= next_disk_en;
      disk_if_base <= next_disk_base;

      // Serial ports; software modes keep them off.
      serial_a_en <= (software_board_mode || software_addin_mode) ? 1'b0 : ser_a_en_d; // [R08]
      serial_a_base <= ser_a_base_d;
      serial_a_irq <= ser_a_irq_d;
      serial_b_en <= (software_board_mode || software_addin_mode) ? 1'b0 : ser_b_en_d; // [R08]
      serial_b_base <= ser_b_base_d;
      serial_b_irq <= ser_b_irq_d;

      // Parallel port.
      parallel_en <= (software_board_mode || software_addin_mode) ? 1'b0 : par_en_d; // [R08]
      parallel_base <= par_base_d;
      parallel_irq <= par_irq_d;
      parallel_mode <= par_mode_d; // [R12]

      // Chip-wide settings.
      clock_is_24mhz <= !clock_freq_strap; // [R15]
      voltage_3v3 <= voltage_strap; // [R16]
      config_reg_index_addr <= next_reg_addr;
    end
  end
endmodule

//--- test/rsod_strap_decoder_assertions.sv
`timescale 1ns/100ps
module rsod_strap_decoder_assertions (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hard_reset_in,
  input wire logic [1:0] config_mode_strap,
  input wire logic disk_select_1_n,
  input wire logic disk_select_0_n,
  input wire logic serial_tx_port_a,
  input wire logic serial_tx_port_b,
  input wire logic request_send_a_n,
  input wire logic request_send_b_n,
  input wire logic terminal_ready_b_n,
  input wire logic config_done,
  input wire logic floppy_controller_en,
  input wire logic [9:0] floppy_controller_base,
  input wire logic floppy_four_drives,
  input wire logic disk_if_en,
  input wire logic [9:0] disk_if_base,
  input wire logic serial_a_en,
  input wire logic [9:0] serial_a_base,
  input wire logic [3:0] serial_a_irq,
  input wire logic serial_b_en,
  input wire logic parallel_en,
  input wire logic [9:0] parallel_base,
  input wire logic [3:0] parallel_irq,
  input rsod_pkg::rsod_par_mode_type parallel_mode,
  input wire logic clock_is_24mhz,
  input wire logic voltage_3v3
);
  // One clock domain, so clocking and disable are stated once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Single-sample modes finish on the edge after the falling edge is seen.
  property p_done_short;
    $fell(hard_reset_in) && config_mode_strap != 2'h2 |=> config_done;
  endproperty
  a_done_short: assert property (p_done_short) else $error("done late");
  // Extended mode waits five edges for the second sample.
  property p_done_ext;
    $fell(hard_reset_in) && config_mode_strap == 2'h2 |-> ##1 !config_done [*5] ##1 config_done;
  endproperty
  a_done_ext: assert property (p_done_ext) else $error("ext done timing");
  property p_sw_defaults;
    $fell(hard_reset_in) && !config_mode_strap[1] |-> ##2 !serial_a_en && !serial_b_en &&
      !parallel_en && floppy_controller_en && floppy_controller_base == 10'h3F6 &&
      !floppy_four_drives && disk_if_en && disk_if_base == 10'h1F0;
  endproperty
  a_sw_defaults: assert property (p_sw_defaults) else $error("sw defaults");
  property p_drive_code;
    $fell(hard_reset_in) && config_mode_strap == 2'h3 |-> ##2
      floppy_controller_en == ($past(disk_select_1_n, 2) | $past(disk_select_0_n, 2)) &&
      disk_if_en == $past(disk_select_1_n, 2);
  endproperty
  a_drive_code: assert property (p_drive_code) else $error("drive code");
  property p_ser_irq;
    config_done && serial_a_en |-> serial_a_irq == (serial_a_base[8] ? 4'h4 : 4'h3);
  endproperty
  a_ser_irq: assert property (p_ser_irq) else $error("serial irq");
  property p_par_irq;
    config_done && parallel_en |-> parallel_irq == (parallel_base == 10'h278 ? 4'h5 : 4'h7);
  endproperty
  a_par_irq: assert property (p_par_irq) else $error("parallel irq");
  property p_sw_straps;
    $fell(hard_reset_in) && !config_mode_strap[1] |-> ##2
      voltage_3v3 == $past(terminal_ready_b_n, 2) && clock_is_24mhz != $past(serial_tx_port_a, 2);
  endproperty
  a_sw_straps: assert property (p_sw_straps) else $error("sw straps");
  property p_ext_bank;
    $fell(hard_reset_in) && config_mode_strap == 2'h2 |-> ##7 parallel_mode ==
      rsod_pkg::rsod_par_mode_type'({$past(request_send_a_n, 7), $past(serial_tx_port_b, 7)}) &&
      floppy_four_drives == $past(request_send_b_n, 7);
  endproperty
  a_ext_bank: assert property (p_ext_bank) else $error("first bank");
  // Three done cycles in a row skip the one edge where fresh outputs land.
  property p_hold;
    config_done && $past(config_done) && $past(config_done, 2) |->
      $stable(serial_a_base) && $stable(parallel_base) && $stable(floppy_controller_en);
  endproperty
  a_hold: assert property (p_hold) else $error("options moved");
  property p_done_drop;
    $rose(hard_reset_in) |=> !config_done;
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("done stuck");
  c_basic: cover property ($fell(hard_reset_in) && config_mode_strap == 2'h3);
  c_ext: cover property ($fell(hard_reset_in) && config_mode_strap == 2'h2);
  c_soft: cover property ($fell(hard_reset_in) && config_mode_strap == 2'h1);
endmodule
bind rsod_strap_decoder rsod_strap_decoder_assertions i_rsod_strap_decoder_assertions (
  .clk_sys, .reset, .hard_reset_in, .config_mode_strap, .disk_select_1_n, .disk_select_0_n,
  .serial_tx_port_a, .serial_tx_port_b, .request_send_a_n, .request_send_b_n,
  .terminal_ready_b_n, .config_done, .floppy_controller_en, .floppy_controller_base,
  .floppy_four_drives, .disk_if_en, .disk_if_base, .serial_a_en, .serial_a_base,
  .serial_a_irq, .serial_b_en, .parallel_en, .parallel_base, .parallel_irq,
  .parallel_mode, .clock_is_24mhz, .voltage_3v3);

//--- test/rsod_strap_bank.sv
`timescale 1ns/100ps
module rsod_strap_bank (
  input wire logic clk_sys,
  input wire logic hard_reset_in,
  input wire logic [5:0] bank_a,
  input wire logic [5:0] bank_b,
  output logic [5:0] pins
);
  logic buffer_on;
  // The buffer lets go one edge after reset negates; releasing at once would race the sample.
  always_ff @(posedge clk_sys) begin
    buffer_on <= hard_reset_in;
  end
  // A pin always sees the buffer or its pull resistor, so it never floats.
  // A four-drive strap leaves the extra drive-select decode to the board.
  assign pins = buffer_on ? bank_a : bank_b;
endmodule

//--- test/rsod_strap_decoder_test.sv
`timescale 1ns/100ps
module rsod_strap_decoder_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hard_reset_in = 1'b0;
  logic [1:0] mode_s = 2'h3;
  logic [1:0] ds = 2'h0;
  logic [5:0] bank_a = 6'h00;
  logic [5:0] bank_b = 6'h00;
  logic [5:0] pins;
  logic [1:0] cm;
  logic done, fe, ff4, de, sae, sbe, pe, c24, v33;
  logic [9:0] fb, db, sab, sbb, pb, ra;
  logic [3:0] sai, sbi, pi;
  rsod_pkg::rsod_par_mode_type pm;
  int bad_count = 0;
  int n_compared = 0;
  logic [9:0] ser_a_tab [16] = '{10'h000, 10'h3F8, 10'h2F8, 10'h3E8, 10'h000, 10'h000,
    10'h2F8, 10'h3E8, 10'h000, 10'h3F8, 10'h2E8, 10'h3E8, 10'h000, 10'h3F8, 10'h2F8, 10'h3E8};
  logic [9:0] ser_b_tab [16] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h3F8, 10'h3E8,
    10'h3F8, 10'h3F8, 10'h2F8, 10'h2F8, 10'h000, 10'h2F8, 10'h2E8, 10'h2E8, 10'h2E8, 10'h2E8};
  logic [9:0] par_tab [4] = '{10'h000, 10'h378, 10'h278, 10'h3BC};
  logic [3:0] par_irq_tab [4] = '{4'h0, 4'h7, 4'h5, 4'h7};
  // The board straps sit behind the buffer model; the drive and mode straps are direct.
  rsod_strap_bank i_rsod_strap_bank (.clk_sys(clk_sys), .hard_reset_in(hard_reset_in),
    .bank_a(bank_a), .bank_b(bank_b), .pins(pins));
  rsod_strap_decoder i_rsod_strap_decoder (
    .clk_sys(clk_sys), .reset(reset), .hard_reset_in(hard_reset_in),
    .config_mode_strap(mode_s), .disk_select_1_n(ds[1]), .disk_select_0_n(ds[0]),
    .serial_tx_port_a(pins[0]), .serial_tx_port_b(pins[1]), .request_send_a_n(pins[2]),
    .request_send_b_n(pins[3]), .terminal_ready_a_n(pins[4]), .terminal_ready_b_n(pins[5]),
    .config_mode(cm), .config_done(done), .floppy_controller_en(fe),
    .floppy_controller_base(fb), .floppy_four_drives(ff4), .disk_if_en(de),
    .disk_if_base(db), .serial_a_en(sae), .serial_a_base(sab), .serial_a_irq(sai),
    .serial_b_en(sbe), .serial_b_base(sbb), .serial_b_irq(sbi), .parallel_en(pe),
    .parallel_base(pb), .parallel_irq(pi), .parallel_mode(pm), .clock_is_24mhz(c24),
    .voltage_3v3(v33), .config_reg_index_addr(ra));
  // Free-running system clock of 100 ns.
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask
  task automatic cmp_val(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A zero base means the unit must be off; bases of disabled units are not looked at.
  task automatic chk_unit(input string nm, input logic [9:0] eb, input logic [3:0] eq,
                          input logic en, input logic [9:0] b, input logic [3:0] q);
    cmp_bit({nm, "_en"}, eb != 10'h000, en);
    if (eb != 10'h000) begin
      cmp_val({nm, "_base"}, eb, b);
      cmp_val({nm, "_irq"}, {6'h00, eq}, {6'h00, q});
    end
  endtask
  function automatic logic [3:0] ser_irq(input logic [9:0] b);
    return (b == 10'h000) ? 4'h0 : (b[8] ? 4'h4 : 4'h3);
  endfunction
  // One hard reset pulse; outputs settle one edge after done rises.
  task automatic run_cfg(input logic [1:0] m, input logic [1:0] d, input logic [5:0] a,
                         input logic [5:0] b);
    int k;
    @(posedge clk_sys);
    mode_s <= m;
    ds <= d;
    bank_a <= a;
    bank_b <= b;
    hard_reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    hard_reset_in <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (done !== 1'b1) begin
      cmp_bit("config_done", 1'b1, done);
      tally_and_finish();
    end
    @(posedge clk_sys);
    #1;
    cmp_val("config_mode", {8'h00, m}, {8'h00, cm});
  endtask
  task automatic chk_drive(input logic [1:0] d);
    chk_unit("floppy", d == 2'h0 ? 10'h000 : (d == 2'h2 ? 10'h370 : 10'h3F6), 4'h0,
      fe, fb, 4'h0);
    chk_unit("disk", d[1] ? (d[0] ? 10'h1F0 : 10'h170) : 10'h000, 4'h0, de, db, 4'h0);
  endtask
  // All sixteen serial codes in basic mode, parallel and drive codes cycling alongside.
  task automatic sc_basic;
    logic [3:0] s;
    for (int i = 0; i < 16; i++) begin
      s = 4'(i);
      run_cfg(2'h3, s[3:2], {s[1:0], s}, {s[1:0], s});
      chk_unit("serial_a", ser_a_tab[i], ser_irq(ser_a_tab[i]), sae, sab, sai);
      chk_unit("serial_b", ser_b_tab[i], ser_irq(ser_b_tab[i]), sbe, sbb, sbi);
      chk_unit("parallel", par_tab[s[1:0]], par_irq_tab[s[1:0]], pe, pb, pi);
      chk_drive(s[3:2]);
      cmp_val("parallel_mode", 10'h000, {8'h00, pm});
      cmp_bit("four_drives", 1'b0, ff4);
      cmp_bit("voltage_3v3", 1'b0, v33);
      cmp_bit("clock_24mhz", 1'b1, c24);
      cmp_val("reg_addr", 10'h398, ra);
    end
  endtask
  // Extended mode: first bank differs from the second so a swapped sample shows.
  task automatic sc_ext;
    logic [1:0] p;
    logic [3:0] s;
    for (int i = 0; i < 4; i++) begin
      p = 2'h1 + {1'b0, i[0]}; // Only 378 or 278 are strapped, as EPP needs.
      s = 4'(i * 5 + 3);
      // Clock strap held low in the first bank.
      run_cfg(2'h2, 2'(3 - i), {~i[0], i[1], i[0], i[1], i[0], 1'b0}, {p, s});
      cmp_val("parallel_mode", 10'(i), {8'h00, pm});
      cmp_bit("four_drives", i[0], ff4);
      cmp_bit("voltage_3v3", ~i[0], v33);
      cmp_bit("clock_24mhz", 1'b1, c24);
      cmp_val("reg_addr", i[1] ? 10'h398 : 10'h26E, ra);
      chk_unit("serial_a", ser_a_tab[s], ser_irq(ser_a_tab[s]), sae, sab, sai);
      chk_unit("serial_b", ser_b_tab[s], ser_irq(ser_b_tab[s]), sbe, sbb, sbi);
      chk_unit("parallel", par_tab[p], par_irq_tab[p], pe, pb, pi);
      chk_drive(2'(3 - i));
    end
  endtask
  // Software modes with every other strap pulled active; only three straps may count.
  task automatic sc_soft;
    logic v;
    for (int i = 0; i < 4; i++) begin
      v = i[0] ^ i[1];
      run_cfg({1'b0, i[0]}, 2'h0, {v, i[1], 4'hE}, {v, i[1], 4'hE});
      chk_drive(2'h3);
      chk_unit("serial_a", 10'h000, 4'h0, sae, sab, sai);
      chk_unit("serial_b", 10'h000, 4'h0, sbe, sbb, sbi);
      chk_unit("parallel", 10'h000, 4'h0, pe, pb, pi);
      cmp_bit("four_drives", 1'b0, ff4);
      cmp_bit("voltage_3v3", v, v33);
      cmp_bit("clock_24mhz", 1'b1, c24);
      cmp_val("reg_addr", i[0] ? (i[1] ? 10'h398 : 10'h26E) :
        (i[1] ? 10'h024 : 10'h022), ra);
    end
  endtask
  // Straps moving after sampling, and a new pulse starting, must leave options in place.
  task automatic sc_hold;
    @(posedge clk_sys);
    ds <= 2'h0;
    mode_s <= 2'h2;
    bank_a <= 6'h3F;
    bank_b <= 6'h3F;
    repeat (8) @(posedge clk_sys);
    #1;
    cmp_val("reg_addr", 10'h398, ra);
    cmp_bit("floppy_en", 1'b1, fe);
    @(posedge clk_sys);
    hard_reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_bit("config_done", 1'b0, done);
    cmp_bit("serial_a_en", 1'b0, sae);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    sc_basic();
    sc_ext();
    sc_soft();
    sc_hold();
    tally_and_finish();
  end
endmodule
